// ### rtl/fault_supervisor.sv
// Purpose: Latches converter faults and commands switch-off and shutdown
// Assumes: Comparator verdicts are asynchronous levels, high when true
// Notes: Overload run starts at a switching cycle pulse once soft-start is done and ends on any clock without the verdict
module fault_supervisor #(
  parameter int unsigned QUAL_CYCLES = fault_supervisor_pkg::QUAL_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic master_enable_pin_in,
  input wire logic internal_supply_por_in,
  input wire logic sys_rail_uv_in,
  input wire logic sys_rail_ok_in,
  input wire logic supply_monitor_ov_in,
  input wire logic supply_monitor_uv_in,
  input wire logic ch1_uv1_in,
  input wire logic ch1_uv2_in,
  input wire logic ch1_ov_in,
  input wire logic ch2_ov_in,
  input wire logic [4:0] soft_start_done_in,
  input wire logic ch1_precharge_done_in,
  input wire logic [4:0] current_limit_in,
  input wire logic [4:0] feedback_uv_in,
  input wire logic [3:0] overload_in,
  input wire logic [4:0] switch_cycle_in,
  output logic [4:0] switches_off_out,
  output logic [4:0] channel_latched_out,
  output logic supply_ov_active_out,
  output logic pmu_shutdown_out
);
  // Two stage synchronisers for all analog verdicts
  localparam int unsigned NSYNC = 35;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign raw = {master_enable_pin_in, internal_supply_por_in,
    sys_rail_uv_in, sys_rail_ok_in, supply_monitor_ov_in,
    supply_monitor_uv_in, ch1_uv1_in, ch1_uv2_in, ch1_ov_in, ch2_ov_in,
    soft_start_done_in, ch1_precharge_done_in, current_limit_in,
    feedback_uv_in, overload_in, switch_cycle_in};
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic en_s;
  logic por_s;
  logic sys_uv_s;
  logic sys_ok_s;
  logic mon_ov_s;
  logic mon_uv_s;
  logic uv1_s;
  logic uv2_s;
  logic ov1_s;
  logic ov2_s;
  logic [4:0] ss_s;
  logic pre_s;
  logic [4:0] cl_s;
  logic [4:0] fbuv_s;
  logic [3:0] ol_s;
  logic [4:0] cyc_s;
  assign {en_s, por_s, sys_uv_s, sys_ok_s, mon_ov_s, mon_uv_s, uv1_s,
    uv2_s, ov1_s, ov2_s, ss_s, pre_s, cl_s, fbuv_s, ol_s, cyc_s} = sync2_reg;

  // Clear of the channel, qualified and supply undervoltage latches; takes priority since the fault source is gone
  logic clear_all;
  assign clear_all = por_s | !en_s;

  // Overload persistence per switching cycle: a run starts at a cycle pulse
  // with the verdict once soft-start is done; any clock without the verdict breaks the run
  logic [3:0] ol_run_reg;
  logic [3:0] ol_run_next;
  logic [4:0] cyc_d_reg;
  logic [4:0] cyc_edge;
  assign cyc_edge = cyc_s & ~cyc_d_reg;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!ol_s[i]) begin
        ol_run_next[i] = 1'b0;
      end else if (cyc_edge[i] && ss_s[i]) begin
        ol_run_next[i] = 1'b1;
      end else begin
        ol_run_next[i] = ol_run_reg[i];
      end
    end
  end

  // Qualified conditions
  logic [10:0] qcond;
  logic [10:0] qexp;
  assign qcond[0] = mon_ov_s;
  assign qcond[1] = uv1_s & ss_s[0];
  assign qcond[2] = ol_run_reg[0];
  assign qcond[3] = ol_run_reg[1];
  assign qcond[4] = ol_run_reg[2];
  assign qcond[5] = ol_run_reg[3];
  assign qcond[6] = cl_s[0];
  assign qcond[7] = cl_s[1];
  assign qcond[8] = cl_s[2];
  assign qcond[9] = cl_s[3];
  assign qcond[10] = cl_s[4];

  genvar g;
  generate
    for (g = 0; g < fault_supervisor_pkg::NUM_QUAL; g++) begin : gen_q
      qual_timer #(.CYCLES(QUAL_CYCLES)) u_qual (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .cond_in(qcond[g]),
        .expired_out(qexp[g])
      );
    end
  endgenerate

  // Immediate latched channel faults
  logic [4:0] inst_fault;
  assign inst_fault[0] = (uv2_s & pre_s) | ov1_s;
  assign inst_fault[1] = (fbuv_s[1] & ss_s[1]) | ov2_s;
  assign inst_fault[2] = fbuv_s[2] & ss_s[2];
  assign inst_fault[3] = fbuv_s[3] & ss_s[3];
  assign inst_fault[4] = fbuv_s[4] & ss_s[4];

  logic [4:0] latch_reg;
  logic [4:0] latch_next;
  logic [4:0] off_reg;
  logic [4:0] off_next;
  logic sys_sd_reg;
  logic sys_sd_next;
  logic qual_sd_reg;
  logic qual_sd_next;
  logic sd_reg;
  logic sd_next;
  logic ovact_reg;
  logic ovact_next;
  // Supply undervoltage latches like the channel faults
  logic supply_uv_reg;
  logic supply_uv_next;

  always_comb begin
    latch_next = latch_reg | inst_fault;
    latch_next[0] = latch_next[0] | qexp[1];
    qual_sd_next = qual_sd_reg | (|qexp[10:1]);
    supply_uv_next = supply_uv_reg | mon_uv_s;
    if (clear_all) begin
      latch_next = fault_supervisor_pkg::CH_NONE;
      qual_sd_next = 1'b0;
      supply_uv_next = 1'b0;
    end
    // Rail undervoltage holds until enable low or rail recovered
    sys_sd_next = sys_sd_reg;
    if (sys_uv_s) begin
      sys_sd_next = 1'b1;
    end else if (!en_s || sys_ok_s) begin
      sys_sd_next = 1'b0;
    end
    // Cycle limits release by themselves on the next cycle
    off_next = latch_next | cl_s;
    if (mon_uv_s || supply_uv_next) begin
      off_next = fault_supervisor_pkg::CH_ALL_OFF;
    end
    ovact_next = mon_ov_s;
    sd_next = sys_sd_next | qual_sd_next | (|latch_next) | mon_uv_s
      | supply_uv_next | qexp[0];
    if (sys_sd_next || sd_next) begin
      off_next = fault_supervisor_pkg::CH_ALL_OFF;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ol_run_reg <= 4'h0;
      cyc_d_reg <= 5'h00;
      latch_reg <= 5'h00;
      off_reg <= 5'h00;
      sys_sd_reg <= 1'b0;
      qual_sd_reg <= 1'b0;
      sd_reg <= 1'b0;
      ovact_reg <= 1'b0;
      supply_uv_reg <= 1'b0;
    end else begin
      ol_run_reg <= ol_run_next;
      cyc_d_reg <= cyc_s;
      latch_reg <= latch_next;
      off_reg <= off_next;
      sys_sd_reg <= sys_sd_next;
      qual_sd_reg <= qual_sd_next;
      sd_reg <= sd_next;
      ovact_reg <= ovact_next;
      supply_uv_reg <= supply_uv_next;
    end
  end

  assign switches_off_out = off_reg;
  assign channel_latched_out = latch_reg;
  assign supply_ov_active_out = ovact_reg;
  assign pmu_shutdown_out = sd_reg;

  sys_uv_shut_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) sys_uv_s |=> pmu_shutdown_out)
    else $error("Rail undervoltage did not shut down");
  latch_clear_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) clear_all |=> latch_reg == 5'h00)
    else $error("Latch not cleared");
  ch2_ss_mask_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    (!ss_s[1] && !ov2_s && !latch_reg[1] && !clear_all) |=>
    !latch_reg[1])
    else $error("Ch2 latched during soft-start");
  fb_uv_latch_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    (fbuv_s[4] && ss_s[4] && !clear_all) |=> latch_reg[4])
    else $error("Ch5 undervoltage not latched");
  latch_hold_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    (latch_reg[2] && !clear_all) |=> latch_reg[2])
    else $error("Ch3 latch dropped");
  cl_off_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) cl_s[3] |=> switches_off_out[3])
    else $error("Ch4 limit did not switch off");
  ol_break_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) !ol_s[0] |=> !ol_run_reg[0])
    else $error("Overload run not broken");
  supply_uv_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    mon_uv_s |=> (switches_off_out == 5'h1f) && pmu_shutdown_out)
    else $error("Supply undervoltage not acted on");
  supply_uv_hold_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    (supply_uv_reg && !clear_all) |=> pmu_shutdown_out)
    else $error("Supply undervoltage latch dropped");
  ch1_uv2_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    (uv2_s && pre_s && !clear_all) |=> latch_reg[0])
    else $error("Ch1 undervoltage two not latched");
endmodule : fault_supervisor

// ### shared/fault_supervisor_pkg.sv
// Purpose: Constants shared by the power fault supervisor
// Assumes: 40 MHz core clock, comparator verdicts arrive asynchronously
package fault_supervisor_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned QUAL_TIME_MS = 100;
  localparam int unsigned QUAL_CYCLES = CLK_HZ / 1000 * QUAL_TIME_MS;
  localparam int unsigned NUM_CH = 5;
  localparam int unsigned NUM_QUAL = 11;
  localparam logic [4:0] CH_ALL_OFF = 5'h1f;
  localparam logic [4:0] CH_NONE = 5'h00;
endpackage : fault_supervisor_pkg

// ### rtl/qual_timer.sv
// Purpose: Qualifies a condition held continuously for a given time
// Assumes: Condition is synchronous to the clock
// Notes: Counter restarts on any drop of the condition
module qual_timer #(
  parameter int unsigned CYCLES = 4_000_000
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic cond_in,
  output logic expired_out
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic expired_reg;
  logic expired_next;

  always_comb begin
    count_next = 32'h0;
    expired_next = 1'b0;
    if (cond_in) begin
      if (count_reg >= CYCLES - 1) begin
        count_next = count_reg;
        expired_next = 1'b1;
      end else begin
        count_next = count_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= 32'h0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired_out = expired_reg;

  qual_restart_a: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) !cond_in |=> !expired_reg)
    else $error("Qualify timer did not restart");
endmodule : qual_timer

// ### dv/comparator_model.sv
// Purpose: Comparator front end: switching cycles and overload verdicts
// Assumes: All channels switch together, one cycle every PERIOD clocks
// Notes: Overload verdict moves only one clock after a cycle start, like a real
// comparator sampled against the ramp; no glitch inside a cycle
module comparator_model #(
  parameter int unsigned PERIOD = 4
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] overload_cmd_in,
  output logic [4:0] switch_cycle_out,
  output logic [3:0] overload_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] count_reg;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= 8'h00;
      overload_out <= 4'h0;
    end else begin
      count_reg <= (count_reg == 8'(PERIOD - 1)) ? 8'h00 : count_reg + 8'h01;
      if (count_reg == 8'h00) begin
        overload_out <= overload_cmd_in;
      end
    end
  end
  assign switch_cycle_out = (count_reg < 8'(PERIOD / 2)) ? 5'h1f : 5'h00;
endmodule : comparator_model

// ### dv/fault_supervisor_tb_top.sv
// Purpose: Self-checking bench for the power fault supervisor
// Assumes: Qualification shortened to 20 cycles
// Notes: Waits leave margin for the two-flop input synchronisers
module fault_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic en = 1'b1, por = 1'b0, uv = 1'b0, ok = 1'b1, pc = 1'b1;
  logic [4:0] ss = 5'h1f;
  logic [7:0] fi = 8'h00;
  logic [10:0] q = 11'h000;
  logic [4:0] sc, so, lat;
  logic [3:0] ol;
  logic sa, sd;
  int errors = 0;
  int checks = 0;
  always #12.5 core_clk_in = ~core_clk_in;
  comparator_model u_model (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .overload_cmd_in(q[9:6]),
    .switch_cycle_out(sc), .overload_out(ol));
  fault_supervisor #(.QUAL_CYCLES(20)) u_dut (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .master_enable_pin_in(en),
    .internal_supply_por_in(por), .sys_rail_uv_in(uv), .sys_rail_ok_in(ok),
    .supply_monitor_ov_in(q[10]), .supply_monitor_uv_in(fi[0]),
    .ch1_uv1_in(q[0]), .ch1_uv2_in(fi[1]), .ch1_ov_in(fi[2]),
    .ch2_ov_in(fi[3]), .soft_start_done_in(ss), .ch1_precharge_done_in(pc),
    .current_limit_in(q[5:1]), .feedback_uv_in({fi[7:4], 1'b0}),
    .overload_in(ol), .switch_cycle_in(sc), .switches_off_out(so),
    .channel_latched_out(lat), .supply_ov_active_out(sa),
    .pmu_shutdown_out(sd));
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : wt
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic clear_en;
    en <= 1'b0;
    wt(5);
    en <= 1'b1;
    wt(5);
  endtask : clear_en
  task automatic t_rail;
    uv <= 1'b1;
    ok <= 1'b0;
    wt(5);
    chk({4'h0, sd}, 5'h01);
    uv <= 1'b0;
    wt(5);
    chk({4'h0, sd}, 5'h01);
    ok <= 1'b1;
    wt(5);
    chk({4'h0, sd}, 5'h00);
    uv <= 1'b1;
    ok <= 1'b0;
    wt(5);
    chk({4'h0, sd}, 5'h01);
    chk(so, 5'h1f);
    uv <= 1'b0;
    wt(3);
    clear_en;
    chk({4'h0, sd}, 5'h00);
    ok <= 1'b1;
    wt(5);
  endtask : t_rail
  task automatic t_instant;
    logic [4:0] e;
    for (int i = 0; i < 8; i++) begin
      case (i)
        0: e = 5'h00;
        1, 2: e = 5'h01;
        3, 4: e = 5'h02;
        5: e = 5'h04;
        6: e = 5'h08;
        default: e = 5'h10;
      endcase
      fi <= 8'h01 << i;
      wt(5);
      chk({4'h0, sd}, 5'h01);
      chk(so, 5'h1f);
      chk(lat, e);
      fi <= 8'h00;
      wt(3);
      chk({4'h0, sd}, 5'h01);
      clear_en;
      chk({4'h0, sd}, 5'h00);
    end
  endtask : t_instant
  task automatic t_masked;
    ss <= 5'h00;
    fi <= 8'h10;
    wt(8);
    chk({4'h0, sd}, 5'h00);
    ss <= 5'h1f;
    wt(5);
    chk(so, 5'h1f);
    chk(lat, 5'h02);
    fi <= 8'h00;
    por <= 1'b1;
    wt(5);
    por <= 1'b0;
    wt(5);
    chk({4'h0, sd}, 5'h00);
  endtask : t_masked
  task automatic t_qual;
    for (int i = 0; i < 11; i++) begin
      q <= 11'h001 << i;
      wt(10);
      chk({4'h0, sd}, 5'h00);
      if (i == 10) begin
        chk({4'h0, sa}, 5'h01);
      end
      if (i >= 1 && i <= 5) begin
        chk(so, 5'h01 << (i - 1));
      end
      wt(30);
      chk({4'h0, sd}, 5'h01);
      if (i == 0) begin
        chk(lat, 5'h01);
      end
      q <= 11'h000;
      wt(8);
      if (i == 10) begin
        chk({4'h0, sd}, 5'h00);
        chk({4'h0, sa}, 5'h00);
      end
      clear_en;
    end
  endtask : t_qual
  task automatic t_break;
    for (int i = 0; i < 3; i++) begin
      q <= 11'h040;
      wt(14);
      q <= 11'h000;
      wt(8);
    end
    chk({4'h0, sd}, 5'h00);
    q <= 11'h004;
    wt(5);
    chk(so, 5'h02);
    q <= 11'h000;
    wt(5);
    chk(so, 5'h00);
  endtask : t_break
  initial begin
    wt(20);
    reset_n_in <= 1'b1;
    wt(3);
    chk({sd, so[3:0]}, 5'h00);
    t_rail();
    t_instant();
    t_masked();
    t_qual();
    t_break();
    end_sim();
  end
  initial begin
    wt(5000);
    errors++;
    end_sim();
  end
endmodule : fault_supervisor_tb_top
